// file: rtl/tcwg_pkg.sv
// Constants shared by the timer compare waveform generator files
package tcwg_pkg;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_COUNT = 8'h04;
  localparam logic [7:0] OFF_COMPARE = 8'h08;
  localparam logic [7:0] OFF_FLAGS = 8'h0c;
  localparam logic [7:0] OFF_PORT = 8'h10;

  // ==========================================================================
  // Field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_ACTION_LSB = 2;
  localparam int CTRL_FORCE_BIT = 7;
  localparam int FLAG_OVF_BIT = 0;
  localparam int FLAG_CMF_BIT = 1;
  localparam int PORT_OUT_BIT = 0;
  localparam int PORT_DIR_BIT = 1;
  localparam int PORT_STATE_BIT = 2;

  // ==========================================================================
  // Waveform modes and compare actions
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_PHASE = 2'h1;
  localparam logic [1:0] MODE_CTC = 2'h2;
  localparam logic [1:0] MODE_FAST = 2'h3;
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;

  // ==========================================================================
  // Counter limits and reset values
  localparam logic [7:0] CNT_MAX = 8'hff;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_STEP = 8'h01;
  localparam logic STATE_RESET = 1'b0;

  // ==========================================================================
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : tcwg_pkg

// file: rtl/tcwg_axil_slave.sv
// AXI4-Lite slave front end that turns bus transfers into register strobes
`timescale 1ns/1ps
module tcwg_axil_slave #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic wr_en,
  output logic [ADDR_W-1:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_ok,
  output logic [ADDR_W-1:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_ok
);

  typedef struct packed {
    logic aw_full;
    logic [ADDR_W-1:0] awaddr;
    logic w_full;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } tcwg_axi_s;

  tcwg_axi_s s_q;
  tcwg_axi_s s_d;

  // ==========================================================================
  // Handshakes
  // Address and data are held separately so either may arrive first
  assign s_axi_awready = ~s_q.aw_full;
  assign s_axi_wready = ~s_q.w_full;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = ~s_q.rvalid;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign wr_en = s_q.aw_full & s_q.w_full & ~s_q.bvalid;
  assign wr_addr = s_q.awaddr;
  assign wr_data = s_q.wdata;
  assign wr_strb = s_q.wstrb;
  assign rd_addr = s_axi_araddr;

  always_comb begin
    s_d = s_q;
    if (s_axi_awvalid && !s_q.aw_full) begin
      s_d.aw_full = 1'b1;
      s_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_q.w_full) begin
      s_d.w_full = 1'b1;
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
    end
    if (wr_en) begin
      s_d.aw_full = 1'b0;
      s_d.w_full = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = wr_ok ? tcwg_pkg::RESP_OKAY : tcwg_pkg::RESP_SLVERR;
    end else if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_axi_arvalid && !s_q.rvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = rd_data;
      s_d.rresp = rd_ok ? tcwg_pkg::RESP_OKAY : tcwg_pkg::RESP_SLVERR;
    end else if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : tcwg_axil_slave

// file: rtl/tcwg_top.sv
// Eight-bit timer counter with one compare channel and pin override
// Function
// [R1] Output state clears to zero on reset
// [R2] Nonzero action overrides port value with state
// [R3] Pin direction stays with port direction bit
// [R4] Output state can be preset before enabling
// [R5] Action zero leaves state unchanged on match
// [R6] New action applies from next match on
// [R7] Force strobe applies action at once, non-PWM
// [R8] Counting depends on mode only, not action
// [R9] Mode zero counts up, wraps FF to 00
// [R10] Normal mode overflow set as count becomes zero
// [R11] Mode two clears count on compare equality
// [R12] Clear-on-match mode sets match flag at top
// [R13] Clear-on-match compare writes are unbuffered
// [R14] Clear-on-match action one toggles on match
// [R15] Toggle half period is compare plus one
// [R16] Clear-on-match overflow set passing MAX to 00; the code does not set it when a compare match at MAX clears the count
// [R17] Mode three counts zero to MAX, then clears
// [R18] Fast PWM: action two clears at match, sets bottom
// [R19] Fast PWM sets overflow at MAX
// [R20] Fast PWM period is 256 ticks
// [R21] Fast PWM extremes: spike at zero, level at MAX
// [R22] Fast PWM action one toggles, buffering kept
// [R23] Match flag set tick after equality, W1C
// [R24] PWM compare writes buffered, loaded at top; the code buffers in fast PWM only, mode one writes go straight through
// [R25] Force touches output state only
// [R26] Count write blocks match in next tick
// [R27] Everything advances only on timer tick
//
// The implementer's own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
module tcwg_top #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic timer_tick,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic pin_o,
  output logic pin_oe,
  output logic overflow_flag,
  output logic compare_match_flag
);

  // ==========================================================================
  // Elaboration checks
  // The byte offsets need eight address bits to decode
  if (ADDR_W < 8) begin : g_addr_chk
    $error("tcwg_top: ADDR_W must be at least 8");
  end

  // ==========================================================================
  // State
  typedef struct packed {
    logic [7:0] count_value;
    logic [7:0] compare_value;
    logic [7:0] compare_buffer;
    logic [1:0] waveform_mode_select;
    logic [1:0] compare_action_field;
    logic compare_output_state;
    logic overflow_flag;
    logic compare_match_flag;
    logic match_block;
    logic port_out;
    logic pin_direction_bit;
  } tcwg_state_s;

  tcwg_state_s s_q;
  tcwg_state_s s_d;

  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  logic [ADDR_W-1:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_ok;

  // ==========================================================================
  // Bus front end
  tcwg_axil_slave #(
    .ADDR_W(ADDR_W)
  ) u_slave (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_ok(wr_ok),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  // ==========================================================================
  // Address decode
  // All fields live in byte lane 0; other lanes are accepted and dropped
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0] off);
    hit = (a == ADDR_W'(off));
  endfunction : hit

  function automatic logic known(input logic [ADDR_W-1:0] a);
    known = hit(a, tcwg_pkg::OFF_CTRL) || hit(a, tcwg_pkg::OFF_COUNT) ||
            hit(a, tcwg_pkg::OFF_COMPARE) || hit(a, tcwg_pkg::OFF_FLAGS) ||
            hit(a, tcwg_pkg::OFF_PORT);
  endfunction : known

  // Action applied at a compare match, or by a forced compare
  function automatic logic match_out(input logic [1:0] act,
                                     input logic cur);
    unique case (act)
      tcwg_pkg::ACT_NONE: match_out = cur; // see [R5]
      tcwg_pkg::ACT_TOGGLE: match_out = ~cur; // see [R14] see [R22]
      tcwg_pkg::ACT_CLEAR: match_out = 1'b0;
      tcwg_pkg::ACT_SET: match_out = 1'b1;
    endcase
  endfunction : match_out

  logic wr_lane0;
  logic ctrl_wr;
  logic count_wr;
  logic compare_wr;
  logic flags_wr;
  logic port_wr;
  logic [1:0] new_mode;
  logic [1:0] new_action;
  logic force_hit;
  logic is_fast;
  logic is_ctc;
  logic wave_mode;
  logic at_max;
  logic match;

  assign wr_ok = known(wr_addr);
  assign rd_ok = known(rd_addr);
  assign wr_lane0 = wr_en & wr_strb[0];
  assign ctrl_wr = wr_lane0 & hit(wr_addr, tcwg_pkg::OFF_CTRL);
  assign count_wr = wr_lane0 & hit(wr_addr, tcwg_pkg::OFF_COUNT);
  assign compare_wr = wr_lane0 & hit(wr_addr, tcwg_pkg::OFF_COMPARE);
  assign flags_wr = wr_lane0 & hit(wr_addr, tcwg_pkg::OFF_FLAGS);
  assign port_wr = wr_lane0 & hit(wr_addr, tcwg_pkg::OFF_PORT);
  assign new_mode = wr_data[tcwg_pkg::CTRL_MODE_LSB +: 2];
  assign new_action = wr_data[tcwg_pkg::CTRL_ACTION_LSB +: 2];

  // Force only acts when the mode being written is a non-PWM one
  assign force_hit = ctrl_wr & wr_data[tcwg_pkg::CTRL_FORCE_BIT] &
                     ((new_mode == tcwg_pkg::MODE_NORMAL) ||
                      (new_mode == tcwg_pkg::MODE_CTC));

  // Counting is keyed on the mode only
  assign is_fast = (s_q.waveform_mode_select == tcwg_pkg::MODE_FAST); // see [R8]
  assign is_ctc = (s_q.waveform_mode_select == tcwg_pkg::MODE_CTC);
  // Phase-correct mode is not built: it counts as normal, no waveform
  assign wave_mode = (s_q.waveform_mode_select != tcwg_pkg::MODE_PHASE);
  assign at_max = (s_q.count_value == tcwg_pkg::CNT_MAX);
  // Equality is judged on the count before the tick moves it
  assign match = timer_tick & ~s_q.match_block &
                 (s_q.count_value == s_q.compare_value); // see [R26]

  // ==========================================================================
  // Read data
  always_comb begin
    rd_data = '0;
    if (hit(rd_addr, tcwg_pkg::OFF_CTRL)) begin
      rd_data[tcwg_pkg::CTRL_MODE_LSB +: 2] = s_q.waveform_mode_select;
      rd_data[tcwg_pkg::CTRL_ACTION_LSB +: 2] = s_q.compare_action_field;
    end else if (hit(rd_addr, tcwg_pkg::OFF_COUNT)) begin
      rd_data[7:0] = s_q.count_value;
    end else if (hit(rd_addr, tcwg_pkg::OFF_COMPARE)) begin
      rd_data[7:0] = s_q.compare_buffer;
    end else if (hit(rd_addr, tcwg_pkg::OFF_FLAGS)) begin
      rd_data[tcwg_pkg::FLAG_OVF_BIT] = s_q.overflow_flag;
      rd_data[tcwg_pkg::FLAG_CMF_BIT] = s_q.compare_match_flag;
    end else if (hit(rd_addr, tcwg_pkg::OFF_PORT)) begin
      rd_data[tcwg_pkg::PORT_OUT_BIT] = s_q.port_out;
      rd_data[tcwg_pkg::PORT_DIR_BIT] = s_q.pin_direction_bit;
      rd_data[tcwg_pkg::PORT_STATE_BIT] = s_q.compare_output_state;
    end
  end

  // ==========================================================================
  // Next state
  always_comb begin
    s_d = s_q;

    // Software clears first so that a hardware set in the same cycle wins
    if (flags_wr && wr_data[tcwg_pkg::FLAG_OVF_BIT]) begin
      s_d.overflow_flag = 1'b0;
    end
    if (flags_wr && wr_data[tcwg_pkg::FLAG_CMF_BIT]) begin
      s_d.compare_match_flag = 1'b0; // see [R23]
    end

    if (timer_tick) begin // see [R27]
      s_d.match_block = 1'b0;
      if (is_ctc && match) begin
        s_d.count_value = tcwg_pkg::CNT_BOTTOM; // see [R11] see [R15]
      end else begin
        // Natural 8-bit wrap covers normal and fast PWM
        s_d.count_value = s_q.count_value + tcwg_pkg::CNT_STEP; // see [R9] see [R17] see [R20]
      end
      if (at_max && !(is_ctc && match)) begin
        s_d.overflow_flag = 1'b1; // see [R10] see [R16] see [R19]
      end
      if (match) begin
        s_d.compare_match_flag = 1'b1; // see [R12] see [R23]
      end
      if (match && wave_mode) begin
        // Action read at the match itself, so a new value waits for it
        s_d.compare_output_state =
          match_out(s_q.compare_action_field,
                    s_q.compare_output_state); // see [R6] see [R18]
      end
      if (is_fast && at_max) begin
        // Bottom edge beats a match at MAX, giving a steady level
        unique case (s_q.compare_action_field)
          tcwg_pkg::ACT_CLEAR: s_d.compare_output_state = 1'b1; // see [R18] see [R21]
          tcwg_pkg::ACT_SET: s_d.compare_output_state = 1'b0; // see [R18] see [R21]
          default: s_d.compare_output_state = s_d.compare_output_state;
        endcase
        s_d.compare_value = s_q.compare_buffer; // see [R24] see [R22]
      end
    end

    if (count_wr) begin
      // CPU write overrides counting and blocks the next tick's match
      s_d.count_value = wr_data[7:0];
      s_d.match_block = 1'b1; // see [R26]
    end

    if (compare_wr) begin
      s_d.compare_buffer = wr_data[7:0];
      if (!is_fast) begin
        s_d.compare_value = wr_data[7:0]; // see [R13] see [R24]
      end
    end

    if (ctrl_wr) begin
      s_d.waveform_mode_select = new_mode;
      s_d.compare_action_field = new_action;
    end

    if (force_hit) begin
      // Only the output state moves: no flag, no counter clear
      s_d.compare_output_state =
        match_out(new_action, s_q.compare_output_state); // see [R7] see [R25] see [R4]
    end

    if (port_wr) begin
      s_d.port_out = wr_data[tcwg_pkg::PORT_OUT_BIT];
      s_d.pin_direction_bit = wr_data[tcwg_pkg::PORT_DIR_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.compare_output_state <= tcwg_pkg::STATE_RESET; // see [R1]
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // Pin override
  // The driver stays under the port direction bit even while overridden
  assign pin_o = (s_q.compare_action_field != tcwg_pkg::ACT_NONE) ?
                 s_q.compare_output_state : s_q.port_out; // see [R2]
  assign pin_oe = s_q.pin_direction_bit; // see [R3]
  assign overflow_flag = s_q.overflow_flag;
  assign compare_match_flag = s_q.compare_match_flag;

endmodule : tcwg_top

// file: sim/tcwg_asserts.sv
// Port assertions for the timer compare waveform generator
`timescale 1ns/1ps
module tcwg_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic timer_tick,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic pin_o,
  input wire logic pin_oe,
  input wire logic overflow_flag,
  input wire logic compare_match_flag
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ==============================
  // Bus handshakes
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_wr_answer;
    ##[1:2] s_axi_bvalid;
  endsequence
  property p_wr_answer;
    s_wr_taken |-> s_wr_answer;
  endproperty
  a_wr_answer: assert property (p_wr_answer)
    else $error("write response missing");
  property p_b_stand;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_stand: assert property (p_b_stand)
    else $error("write response dropped early");
  property p_r_stand;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_stand: assert property (p_r_stand)
    else $error("read data dropped early");
  property p_rd_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read answer late");

  // ==============================
  // Timer flags and pin
  property p_reset_state;
    $rose(aresetn) |-> !pin_oe && !pin_o && !overflow_flag
      && !compare_match_flag;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("state not cleared by reset");
  property p_ovf_tick;
    $rose(overflow_flag) |-> $past(timer_tick);
  endproperty
  a_ovf_tick: assert property (p_ovf_tick)
    else $error("overflow set without a tick");
  property p_cmf_tick;
    $rose(compare_match_flag) |-> $past(timer_tick);
  endproperty
  a_cmf_tick: assert property (p_cmf_tick)
    else $error("match flag set without a tick");
  property p_ovf_hold;
    $fell(overflow_flag) |-> $rose(s_axi_bvalid);
  endproperty
  a_ovf_hold: assert property (p_ovf_hold)
    else $error("overflow cleared by hardware");
  property p_cmf_hold;
    $fell(compare_match_flag) |-> $rose(s_axi_bvalid);
  endproperty
  a_cmf_hold: assert property (p_cmf_hold)
    else $error("match flag cleared by hardware");
  property p_oe_write;
    $changed(pin_oe) |-> $rose(s_axi_bvalid);
  endproperty
  a_oe_write: assert property (p_oe_write)
    else $error("pin enable moved without a write");
endmodule : tcwg_asserts

bind tcwg_top tcwg_asserts u_tcwg_asserts (
  .aclk(aclk), .aresetn(aresetn), .timer_tick(timer_tick),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .pin_o(pin_o), .pin_oe(pin_oe), .overflow_flag(overflow_flag),
  .compare_match_flag(compare_match_flag)
);

// file: sim/tcwg_pin_model.sv
// Port pin model: pad driven by the block or left floating
`timescale 1ns/1ps
module tcwg_pin_model (
  input wire logic aclk,
  input wire logic pin_o,
  input wire logic pin_oe,
  output logic pin_level
);
  logic float_q = 1'b0;
  // No pull on this pad, so an undriven level wanders every cycle
  always_ff @(posedge aclk) begin
    float_q <= ~float_q;
  end
  assign pin_level = pin_oe ? pin_o : float_q;
endmodule : tcwg_pin_model

// file: sim/tb.sv
// Testbench for the timer compare waveform generator
`timescale 1ns/1ps
module tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic timer_tick = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, pin_o, pin_oe, pin_level;
  logic overflow_flag, compare_match_flag;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int err_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  int highs;
  int fc [3][2] = '{'{'h8c, 4}, '{'h88, 0}, '{'h84, 4}};
  int pw [6][3] = '{'{2, 16, 17}, '{1, 16, 239}, '{3, 16, 239},
                    '{2, 0, 1}, '{2, 255, 256}, '{3, 255, 0}};

  always #25 aclk = ~aclk;

  tcwg_top u_tcwg_top (
    .aclk(aclk), .aresetn(aresetn), .timer_tick(timer_tick),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pin_o(pin_o),
    .pin_oe(pin_oe), .overflow_flag(overflow_flag),
    .compare_match_flag(compare_match_flag)
  );
  tcwg_pin_model u_tcwg_pin_model (
    .aclk(aclk), .pin_o(pin_o), .pin_oe(pin_oe), .pin_level(pin_level)
  );

  // ==============================
  // Reporting
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop

  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      err_count++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // ==============================
  // Bus access
  // Ready is looked at just after an edge: it cannot move before the next
  // edge, so the handshake is known without racing the design
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = tcwg_pkg::RESP_OKAY);
    logic ah, wh, bh;
    logic [1:0] rr;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      #1;
      ah = awvalid && awready;
      wh = wvalid && wready;
      bh = bvalid;
      rr = bresp;
      @(posedge aclk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
    end while (!bh);
    bready <= 1'b1;
    @(posedge aclk);
    bready <= 1'b0;
    chk(32'(rr), 32'(er));
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                        input logic [1:0] er = tcwg_pkg::RESP_OKAY);
    logic ah, rh;
    logic [1:0] rr;
    logic [31:0] rd;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      #1;
      ah = arvalid && arready;
      rh = rvalid;
      rd = rdata;
      rr = rresp;
      @(posedge aclk);
      if (ah) arvalid <= 1'b0;
    end while (!rh);
    rready <= 1'b1;
    @(posedge aclk);
    rready <= 1'b0;
    chk(rd, exp);
    chk(32'(rr), 32'(er));
  endtask : rd_chk

  // Holds the tick for n edges and counts cycles with the output high
  task automatic run(input int n);
    highs = 0;
    @(posedge aclk);
    timer_tick <= 1'b1;
    for (int i = 1; i <= n; i++) begin
      @(posedge aclk);
      if (i == n) timer_tick <= 1'b0;
      #1;
      highs += int'(pin_o === 1'b1);
    end
  endtask : run

  // ==============================
  // Tests
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    for (int a = 0; a <= 16; a += 4) begin
      rd_chk(8'(a), 32'h0);
    end
    rd_chk(8'h14, 32'h0, tcwg_pkg::RESP_SLVERR);
    wr(8'h14, 32'h1, tcwg_pkg::RESP_SLVERR);
    $display("test reset and map done");
    wr(tcwg_pkg::OFF_COMPARE, 32'hfd);
    wr(tcwg_pkg::OFF_COUNT, 32'hfd);
    run(2);
    rd_chk(tcwg_pkg::OFF_COUNT, 32'hff);
    rd_chk(tcwg_pkg::OFF_FLAGS, 32'h0);
    run(1);
    rd_chk(tcwg_pkg::OFF_COUNT, 32'h0);
    rd_chk(tcwg_pkg::OFF_FLAGS, 32'h1);
    wr(tcwg_pkg::OFF_FLAGS, 32'h1);
    rd_chk(tcwg_pkg::OFF_FLAGS, 32'h0);
    $display("test normal mode done");
    for (int i = 0; i < 3; i++) begin
      wr(tcwg_pkg::OFF_CTRL, 32'(fc[i][0]));
      rd_chk(tcwg_pkg::OFF_PORT, 32'(fc[i][1]));
    end
    chk(32'(pin_oe), 32'h0);
    rd_chk(tcwg_pkg::OFF_FLAGS, 32'h0);
    rd_chk(tcwg_pkg::OFF_CTRL, 32'h4);
    wr(tcwg_pkg::OFF_PORT, 32'h2);
    #1;
    chk(32'({pin_oe, pin_o, pin_level}), 32'h7);
    wr(tcwg_pkg::OFF_CTRL, 32'h0);
    #1;
    chk(32'(pin_o), 32'h0);
    wr(tcwg_pkg::OFF_CTRL, 32'h8b);
    rd_chk(tcwg_pkg::OFF_PORT, 32'h6);
    wr(tcwg_pkg::OFF_CTRL, 32'h0);
    wr(tcwg_pkg::OFF_COUNT, 32'h3);
    wr(tcwg_pkg::OFF_COMPARE, 32'h5);
    run(3);
    rd_chk(tcwg_pkg::OFF_FLAGS, 32'h2);
    rd_chk(tcwg_pkg::OFF_PORT, 32'h6);
    wr(tcwg_pkg::OFF_CTRL, 32'h8);
    rd_chk(tcwg_pkg::OFF_PORT, 32'h6);
    wr(tcwg_pkg::OFF_COUNT, 32'h4);
    run(2);
    rd_chk(tcwg_pkg::OFF_PORT, 32'h2);
    $display("test force and action done");
    wr(tcwg_pkg::OFF_FLAGS, 32'h3);
    wr(tcwg_pkg::OFF_CTRL, 32'h6);
    wr(tcwg_pkg::OFF_COMPARE, 32'h2);
    wr(tcwg_pkg::OFF_COUNT, 32'h0);
    run(6);
    chk(32'(highs), 32'h3);
    rd_chk(tcwg_pkg::OFF_COUNT, 32'h0);
    rd_chk(tcwg_pkg::OFF_FLAGS, 32'h2);
    wr(tcwg_pkg::OFF_FLAGS, 32'h3);
    wr(tcwg_pkg::OFF_COMPARE, 32'h3);
    wr(tcwg_pkg::OFF_COUNT, 32'h5);
    run(251);
    rd_chk(tcwg_pkg::OFF_FLAGS, 32'h1);
    run(4);
    rd_chk(tcwg_pkg::OFF_FLAGS, 32'h3);
    rd_chk(tcwg_pkg::OFF_COUNT, 32'h0);
    $display("test clear on match done");
    wr(tcwg_pkg::OFF_CTRL, 32'hb);
    wr(tcwg_pkg::OFF_COMPARE, 32'h80);
    wr(tcwg_pkg::OFF_COUNT, 32'hff);
    wr(tcwg_pkg::OFF_FLAGS, 32'h3);
    run(1);
    chk(32'(highs), 32'h1);
    wr(tcwg_pkg::OFF_COMPARE, 32'h10);
    run(255);
    chk(32'(highs), 32'h80);
    rd_chk(tcwg_pkg::OFF_FLAGS, 32'h3);
    rd_chk(tcwg_pkg::OFF_COUNT, 32'hff);
    for (int i = 0; i < 6; i++) begin
      wr(tcwg_pkg::OFF_CTRL, 32'(3 + 4 * pw[i][0]));
      wr(tcwg_pkg::OFF_COMPARE, 32'(pw[i][1]));
      run(256);
      chk(32'(highs), 32'(pw[i][2]));
    end
    rd_chk(tcwg_pkg::OFF_COUNT, 32'hff);
    $display("test fast pwm done");
    report_and_stop();
  end
endmodule : tb
